// file: common/tmr8_pkg.sv
// Constants, encodings and helper functions of the 8-bit timer compare unit.
// Assumes a single system clock; all mode decoding is shared through this package.
`default_nettype none

package tmr8_pkg;

  localparam int          CNT_W      = 8;
  localparam logic [7:0]  CNT_BOTTOM = 8'h00;
  localparam logic [7:0]  CNT_MAX    = 8'hFF;
  localparam logic [7:0]  CNT_ONE    = 8'h01;

  // Clock select encodings
  localparam logic [2:0]  CS_STOP     = 3'h0;
  localparam logic [2:0]  CS_DIV1     = 3'h1;
  localparam logic [2:0]  CS_DIV8     = 3'h2;
  localparam logic [2:0]  CS_DIV64    = 3'h3;
  localparam logic [2:0]  CS_DIV256   = 3'h4;
  localparam logic [2:0]  CS_DIV1024  = 3'h5;
  localparam logic [2:0]  CS_EXT_FALL = 3'h6;
  localparam logic [2:0]  CS_EXT_RISE = 3'h7;

  // Shared prescaler: a tap fires when its low bits are all ones
  localparam int          PSC_W        = 10;
  localparam logic [9:0]  PSC_ONE      = 10'h001;
  localparam logic [9:0]  PSC_MASK_8   = 10'h007;
  localparam logic [9:0]  PSC_MASK_64  = 10'h03F;
  localparam logic [9:0]  PSC_MASK_256 = 10'h0FF;
  localparam logic [9:0]  PSC_MASK_1K  = 10'h3FF;

  // Waveform modes; 4 and 6 are reserved and behave as normal
  localparam logic [2:0]  WGM_NORMAL    = 3'h0;
  localparam logic [2:0]  WGM_PC_MAX    = 3'h1;
  localparam logic [2:0]  WGM_CTC       = 3'h2;
  localparam logic [2:0]  WGM_FAST_MAX  = 3'h3;
  localparam logic [2:0]  WGM_PC_OCRA   = 3'h5;
  localparam logic [2:0]  WGM_FAST_OCRA = 3'h7;
  localparam int          WGM_TOP_BIT   = 2;

  // Output action encodings
  localparam logic [1:0]  COM_OFF    = 2'h0;
  localparam logic [1:0]  COM_TOGGLE = 2'h1;
  localparam logic [1:0]  COM_CLEAR  = 2'h2;
  localparam logic [1:0]  COM_SET    = 2'h3;

  // Flag and mask bit positions
  localparam int          FLAG_W       = 3;
  localparam int          FLAG_OVF     = 0;
  localparam int          FLAG_MATCH_A = 1;
  localparam int          FLAG_MATCH_B = 2;

  typedef enum logic {TMR8_DIR_UP = 1'b0, TMR8_DIR_DOWN = 1'b1} tmr8_dir_t;

  function automatic logic tmr8_is_phase(input logic [2:0] wgm);
    return (wgm == WGM_PC_MAX) || (wgm == WGM_PC_OCRA);
  endfunction : tmr8_is_phase

  function automatic logic tmr8_is_fast(input logic [2:0] wgm);
    return (wgm == WGM_FAST_MAX) || (wgm == WGM_FAST_OCRA);
  endfunction : tmr8_is_fast

  function automatic logic tmr8_is_pwm(input logic [2:0] wgm);
    return tmr8_is_phase(wgm) || tmr8_is_fast(wgm);
  endfunction : tmr8_is_pwm

  function automatic logic tmr8_top_is_ocra(input logic [2:0] wgm);
    return (wgm == WGM_CTC) || (wgm == WGM_PC_OCRA) || (wgm == WGM_FAST_OCRA);
  endfunction : tmr8_top_is_ocra

endpackage : tmr8_pkg

`default_nettype wire

// file: rtl/tmr8_clk_sel.sv
// Clock select: shared prescaler taps and external pin edge detector.
// Produces a one-cycle timer tick enable on the system clock.
`timescale 1ns/100ps
`default_nettype none

module tmr8_clk_sel
  import tmr8_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ext_count_pin_i,
  input  wire logic [2:0]  clock_select_field_i,
  input  wire logic        prescaler_clear_bit_i,
  output logic             timer_tick_o
);

  logic [PSC_W-1:0] psc_reg;
  logic [PSC_W-1:0] psc_next;
  logic [2:0]       sync_reg;
  logic [2:0]       sync_next;
  logic             level_reg;
  logic             level_next;
  logic             agree;
  logic             rise;
  logic             fall;

  function automatic logic tap(input logic [PSC_W-1:0] cnt, input logic [PSC_W-1:0] mask);
    return (cnt & mask) == mask;
  endfunction : tap

  // Pin change is taken only once second and third stages agree
  always_comb
  begin
    psc_next   = prescaler_clear_bit_i ? '0 : psc_reg + PSC_ONE;
    sync_next  = {sync_reg[1:0], ext_count_pin_i};
    agree      = (sync_reg[1] == sync_reg[2]);
    level_next = agree ? sync_reg[2] : level_reg;
    rise       = agree & sync_reg[2] & ~level_reg;
    fall       = agree & ~sync_reg[2] & level_reg;
    case (clock_select_field_i)
      CS_STOP     : timer_tick_o = 1'b0;
      CS_DIV1     : timer_tick_o = 1'b1;
      CS_DIV8     : timer_tick_o = tap(psc_reg, PSC_MASK_8);
      CS_DIV64    : timer_tick_o = tap(psc_reg, PSC_MASK_64);
      CS_DIV256   : timer_tick_o = tap(psc_reg, PSC_MASK_256);
      CS_DIV1024  : timer_tick_o = tap(psc_reg, PSC_MASK_1K);
      CS_EXT_FALL : timer_tick_o = fall;
      CS_EXT_RISE : timer_tick_o = rise;
      default     : timer_tick_o = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      psc_reg   <= '0;
      sync_reg  <= '0;
      level_reg <= 1'b0;
    end
    else
    begin
      psc_reg   <= psc_next;
      sync_reg  <= sync_next;
      level_reg <= level_next;
    end
  end

endmodule : tmr8_clk_sel

`default_nettype wire

// file: rtl/tmr8_timer.sv
// Top of the 8-bit timer: counter unit, two compare units, flags and outputs.
// Assumes CPU accesses arrive as single-cycle strobes on the system clock.
//
// Function
// - Eight-bit counter and compares, continuous comparison
// - Clock select zero stops the counter
// - Select internal prescaled or external pin clock
// - Tick clears, increments or decrements per mode
// - CPU counter write beats clear or count
// - Top and bottom indications from counter
// - Match sets flag next tick, masked request
// - Flag cleared by service or writing one
// - One flag register, each gated by mask
// - Overflow flag set per mode, interrupt capable
// - Double buffer compares only in PWM modes
// - Buffered compare loads only at top
// - CPU compare access hits buffer or active
// - Force strobe acts like match outside PWM, no flag
// - Counter write blocks matches next tick
// - Output state kept across modes, reset zero
// - Action bits unbuffered, act at next match
// - Nonzero action bits override port output value
// - Action bits zero leave output state alone
// - Bottom 0x00, max 0xFF, top per mode
// - External clock: 7 rising, 6 falling edge
// - Prescale factors 1, 8, 64, 256, 1024
`timescale 1ns/100ps
`default_nettype none

module tmr8_timer
  import tmr8_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              ext_count_pin_i,
  input  wire logic [2:0]        clock_select_field_i,
  input  wire logic              prescaler_clear_bit_i,
  input  wire logic [2:0]        waveform_mode_field_i,
  input  wire logic [1:0]        output_action_bits_a_i,
  input  wire logic [1:0]        output_action_bits_b_i,
  input  wire logic              count_wr_i,
  input  wire logic [CNT_W-1:0]  count_wdata_i,
  input  wire logic              compare_a_wr_i,
  input  wire logic              compare_b_wr_i,
  input  wire logic [CNT_W-1:0]  compare_wdata_i,
  input  wire logic              force_match_strobe_a_i,
  input  wire logic              force_match_strobe_b_i,
  input  wire logic [FLAG_W-1:0] flag_clear_i,
  input  wire logic [FLAG_W-1:0] int_ack_i,
  input  wire logic [FLAG_W-1:0] timer_mask_register_i,
  input  wire logic [1:0]        port_out_i,
  input  wire logic [1:0]        port_dir_i,
  output logic [CNT_W-1:0]       count_value_o,
  output logic [CNT_W-1:0]       compare_value_a_o,
  output logic [CNT_W-1:0]       compare_value_b_o,
  output logic [FLAG_W-1:0]      timer_flag_register_o,
  output logic [FLAG_W-1:0]      irq_o,
  output logic                   top_o,
  output logic                   bottom_o,
  output logic                   timer_tick_o,
  output logic                   wave_out_a_o,
  output logic                   wave_oe_a_o,
  output logic                   wave_out_b_o,
  output logic                   wave_oe_b_o,
  output logic [1:0]             wave_out_state_o
);

  logic [1:0]        rst_sync_reg;
  logic              rst_n;
  logic              tick;

  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  cnt_next;
  tmr8_dir_t         dir_reg;
  tmr8_dir_t         dir_next;
  logic              block_reg;
  logic              block_next;

  logic [CNT_W-1:0]  buf_a_reg;
  logic [CNT_W-1:0]  buf_a_next;
  logic [CNT_W-1:0]  ocr_a_reg;
  logic [CNT_W-1:0]  ocr_a_next;
  logic [CNT_W-1:0]  buf_b_reg;
  logic [CNT_W-1:0]  buf_b_next;
  logic [CNT_W-1:0]  ocr_b_reg;
  logic [CNT_W-1:0]  ocr_b_next;

  logic [FLAG_W-1:0] flag_reg;
  logic [FLAG_W-1:0] flag_next;
  logic [FLAG_W-1:0] flag_set;

  logic [CNT_W-1:0]  top_val;
  logic              at_top;
  logic              at_bottom;
  logic              pwm;
  logic              upd_ev;
  logic              ovf_ev;
  logic              match_a_ev;
  logic              match_b_ev;
  logic              wrap_ev;

  // Buffer takes every CPU write; active register follows it directly
  // outside PWM, so readback stays coherent across mode changes.
  function automatic logic [CNT_W-1:0] ocr_step(input logic             is_pwm,
                                                input logic             upd,
                                                input logic             wr,
                                                input logic [CNT_W-1:0] wdata,
                                                input logic [CNT_W-1:0] buffered,
                                                input logic [CNT_W-1:0] active);
    logic [CNT_W-1:0] res;
    res = active;
    if (!is_pwm && wr)
      res = wdata;
    else if (is_pwm && upd)
      res = buffered;
    return res;
  endfunction : ocr_step

  // Reset release through two flops
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  assign rst_n = rst_sync_reg[1];

  tmr8_clk_sel u_clk_sel
  (
    .clk_i                 (clk_i),
    .rst_n_i               (rst_n),
    .ext_count_pin_i       (ext_count_pin_i),
    .clock_select_field_i  (clock_select_field_i),
    .prescaler_clear_bit_i (prescaler_clear_bit_i),
    .timer_tick_o          (tick)
  );

  // Decode of extreme values and events
  always_comb
  begin
    pwm        = tmr8_is_pwm(waveform_mode_field_i);
    top_val    = tmr8_top_is_ocra(waveform_mode_field_i) ? ocr_a_reg : CNT_MAX;
    at_top     = (cnt_reg == top_val);
    at_bottom  = (cnt_reg == CNT_BOTTOM);
    upd_ev     = tick & at_top & pwm;
    wrap_ev    = tick & at_top & tmr8_is_fast(waveform_mode_field_i);
    match_a_ev = tick & (cnt_reg == ocr_a_reg) & ~block_reg;
    match_b_ev = tick & (cnt_reg == ocr_b_reg) & ~block_reg;
    if (tmr8_is_phase(waveform_mode_field_i))
      ovf_ev = tick & at_bottom & (dir_reg == TMR8_DIR_DOWN);
    else if (tmr8_is_fast(waveform_mode_field_i))
      ovf_ev = tick & at_top;
    else
      ovf_ev = tick & (cnt_reg == CNT_MAX);
  end

  // Counter unit
  always_comb
  begin
    cnt_next   = cnt_reg;
    dir_next   = dir_reg;
    block_next = tick ? 1'b0 : block_reg;
    if (tick)
    begin
      case (waveform_mode_field_i)
        WGM_CTC, WGM_FAST_MAX, WGM_FAST_OCRA :
          cnt_next = at_top ? CNT_BOTTOM : cnt_reg + CNT_ONE;
        WGM_PC_MAX, WGM_PC_OCRA :
        begin
          if (dir_reg == TMR8_DIR_UP)
          begin
            if (at_top)
            begin
              dir_next = TMR8_DIR_DOWN;
              cnt_next = cnt_reg - CNT_ONE;
            end
            else
              cnt_next = cnt_reg + CNT_ONE;
          end
          else if (at_bottom)
          begin
            dir_next = TMR8_DIR_UP;
            cnt_next = cnt_reg + CNT_ONE;
          end
          else
            cnt_next = cnt_reg - CNT_ONE;
        end
        default :
          cnt_next = cnt_reg + CNT_ONE;
      endcase
    end
    if (!tmr8_is_phase(waveform_mode_field_i))
      dir_next = TMR8_DIR_UP;
    // CPU write wins and arms the one-tick match block, even when stopped
    if (count_wr_i)
    begin
      cnt_next   = count_wdata_i;
      block_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg   <= CNT_BOTTOM;
      dir_reg   <= TMR8_DIR_UP;
      block_reg <= 1'b0;
    end
    else
    begin
      cnt_reg   <= cnt_next;
      dir_reg   <= dir_next;
      block_reg <= block_next;
    end
  end

  // Compare registers with optional double buffer
  always_comb
  begin
    buf_a_next = compare_a_wr_i ? compare_wdata_i : buf_a_reg;
    buf_b_next = compare_b_wr_i ? compare_wdata_i : buf_b_reg;
    ocr_a_next = ocr_step(pwm, upd_ev, compare_a_wr_i, compare_wdata_i, buf_a_reg, ocr_a_reg);
    ocr_b_next = ocr_step(pwm, upd_ev, compare_b_wr_i, compare_wdata_i, buf_b_reg, ocr_b_reg);
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buf_a_reg <= CNT_BOTTOM;
      ocr_a_reg <= CNT_BOTTOM;
      buf_b_reg <= CNT_BOTTOM;
      ocr_b_reg <= CNT_BOTTOM;
    end
    else
    begin
      buf_a_reg <= buf_a_next;
      ocr_a_reg <= ocr_a_next;
      buf_b_reg <= buf_b_next;
      ocr_b_reg <= ocr_b_next;
    end
  end

  // Flags: a set in the same cycle as a clear survives
  always_comb
  begin
    flag_set               = '0;
    flag_set[FLAG_OVF]     = ovf_ev;
    flag_set[FLAG_MATCH_A] = match_a_ev;
    flag_set[FLAG_MATCH_B] = match_b_ev;
    flag_next = (flag_reg & ~(flag_clear_i | int_ack_i)) | flag_set;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      flag_reg <= '0;
    else
      flag_reg <= flag_next;
  end

  assign irq_o                 = flag_reg & timer_mask_register_i;
  assign timer_flag_register_o = flag_reg;
  assign count_value_o         = cnt_reg;
  assign compare_value_a_o     = buf_a_reg;
  assign compare_value_b_o     = buf_b_reg;
  assign top_o                 = at_top;
  assign bottom_o              = at_bottom;
  assign timer_tick_o          = tick;

  // Toggle in PWM is only offered on unit A with the OCRA top modes
  tmr8_wave_out u_wave_a
  (
    .clk_i                 (clk_i),
    .rst_n_i               (rst_n),
    .waveform_mode_field_i (waveform_mode_field_i),
    .output_action_bits_i  (output_action_bits_a_i),
    .toggle_ok_i           (waveform_mode_field_i[WGM_TOP_BIT]),
    .match_i               (match_a_ev),
    .force_i               (force_match_strobe_a_i),
    .wrap_i                (wrap_ev),
    .dir_down_i            (dir_reg == TMR8_DIR_DOWN),
    .port_out_i            (port_out_i[0]),
    .port_dir_i            (port_dir_i[0]),
    .wave_out_o            (wave_out_a_o),
    .wave_oe_o             (wave_oe_a_o),
    .wave_out_state_o      (wave_out_state_o[0])
  );

  tmr8_wave_out u_wave_b
  (
    .clk_i                 (clk_i),
    .rst_n_i               (rst_n),
    .waveform_mode_field_i (waveform_mode_field_i),
    .output_action_bits_i  (output_action_bits_b_i),
    .toggle_ok_i           (1'b0),
    .match_i               (match_b_ev),
    .force_i               (force_match_strobe_b_i),
    .wrap_i                (wrap_ev),
    .dir_down_i            (dir_reg == TMR8_DIR_DOWN),
    .port_out_i            (port_out_i[1]),
    .port_dir_i            (port_dir_i[1]),
    .wave_out_o            (wave_out_b_o),
    .wave_oe_o             (wave_oe_b_o),
    .wave_out_state_o      (wave_out_state_o[1])
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  chk_stop_holds: assert property ((clock_select_field_i == CS_STOP) && !count_wr_i
                                   |=> cnt_reg == $past(cnt_reg))
    else $error("counter moved while stopped");
  chk_write_wins: assert property (count_wr_i |=> cnt_reg == $past(count_wdata_i))
    else $error("counter write lost");
  chk_normal_step: assert property (tick && (waveform_mode_field_i == WGM_NORMAL) && !count_wr_i
                                    |=> cnt_reg == CNT_W'($past(cnt_reg) + CNT_ONE))
    else $error("normal mode did not step by one");
  chk_match_flag: assert property (match_a_ev |=> flag_reg[FLAG_MATCH_A])
    else $error("match A flag not set");
  chk_write_block: assert property ((count_wr_i ##1 tick) |-> !match_a_ev && !match_b_ev)
    else $error("match not blocked after counter write");
  chk_one_clears: assert property (flag_clear_i[FLAG_OVF] && !ovf_ev |=> !flag_reg[FLAG_OVF])
    else $error("overflow flag not cleared");
  chk_ovf_sets: assert property (ovf_ev |=> flag_reg[FLAG_OVF])
    else $error("overflow flag not set");
  chk_irq_mask: assert property (!timer_mask_register_i[FLAG_MATCH_B] |-> !irq_o[FLAG_MATCH_B])
    else $error("masked request raised");
  chk_direct_load: assert property (compare_a_wr_i && !pwm |=> ocr_a_reg == $past(compare_wdata_i))
    else $error("direct compare write missing");
  chk_buffer_hold: assert property (compare_a_wr_i && pwm && !upd_ev |=> ocr_a_reg == $past(ocr_a_reg))
    else $error("buffered compare changed early");
  chk_force_noflag: assert property (force_match_strobe_a_i && !match_a_ev && !flag_reg[FLAG_MATCH_A]
                                     |=> !flag_reg[FLAG_MATCH_A])
    else $error("force set the flag");

  cov_overflow: cover property (ovf_ev && !count_wr_i);
  cov_buffer_load: cover property (upd_ev && (buf_a_reg != ocr_a_reg));
  cov_ctc_match: cover property (match_a_ev && (waveform_mode_field_i == WGM_CTC));

endmodule : tmr8_timer

`default_nettype wire

// file: rtl/tmr8_wave_out.sv
// Compare match output unit: internal output state and port override.
// Expects match and wrap events from the counter and the CPU force strobe as one-cycle enables.
`timescale 1ns/100ps
`default_nettype none

module tmr8_wave_out
  import tmr8_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [2:0]  waveform_mode_field_i,
  input  wire logic [1:0]  output_action_bits_i,
  input  wire logic        toggle_ok_i,
  input  wire logic        match_i,
  input  wire logic        force_i,
  input  wire logic        wrap_i,
  input  wire logic        dir_down_i,
  input  wire logic        port_out_i,
  input  wire logic        port_dir_i,
  output logic             wave_out_o,
  output logic             wave_oe_o,
  output logic             wave_out_state_o
);

  logic state_reg;
  logic state_next;

  // Mode switches never touch the state; only events do
  always_comb
  begin
    state_next = state_reg;
    if (!tmr8_is_pwm(waveform_mode_field_i))
    begin
      if (match_i || force_i)
      begin
        case (output_action_bits_i)
          COM_TOGGLE : state_next = ~state_reg;
          COM_CLEAR  : state_next = 1'b0;
          COM_SET    : state_next = 1'b1;
          default    : state_next = state_reg;
        endcase
      end
    end
    else if (match_i)
    begin
      case (output_action_bits_i)
        COM_TOGGLE : state_next = toggle_ok_i ? ~state_reg : state_reg;
        COM_CLEAR  : state_next = tmr8_is_phase(waveform_mode_field_i) & dir_down_i;
        COM_SET    : state_next = ~(tmr8_is_phase(waveform_mode_field_i) & dir_down_i);
        default    : state_next = state_reg;
      endcase
    end
    else if (wrap_i && tmr8_is_fast(waveform_mode_field_i))
    begin
      case (output_action_bits_i)
        COM_CLEAR : state_next = 1'b1;
        COM_SET   : state_next = 1'b0;
        default   : state_next = state_reg;
      endcase
    end
  end

  // Override follows the action bits at once, direction stays with the port
  assign wave_out_o       = (output_action_bits_i != COM_OFF) ? state_reg : port_out_i;
  assign wave_oe_o        = port_dir_i;
  assign wave_out_state_o = state_reg;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_reg <= 1'b0;
    else
      state_reg <= state_next;
  end

endmodule : tmr8_wave_out

`default_nettype wire

// file: sim/tb_top.sv
// Bench: drives the timer ports and checks counter, flags and pins.
// Assumes the pin model feeds the external count input.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import tmr8_pkg::*;
  logic       clk_i = '0, rst_b_i = '0, ext_count_pin_i, edge_req = '0, prescaler_clear_bit_i = '0;
  logic       count_wr_i = '0, compare_a_wr_i = '0, compare_b_wr_i = '0;
  logic       force_match_strobe_a_i = '0, force_match_strobe_b_i = '0;
  logic [2:0] clock_select_field_i = '0, waveform_mode_field_i = '0;
  logic [2:0] flag_clear_i = '0, int_ack_i = '0, timer_mask_register_i = '0;
  logic [1:0] output_action_bits_a_i = '0, output_action_bits_b_i = '0, port_out_i = '0, port_dir_i = '0;
  logic [7:0] count_wdata_i = '0, compare_wdata_i = '0, count_value_o, compare_value_a_o, compare_value_b_o;
  logic [2:0] timer_flag_register_o, irq_o;
  logic [1:0] wave_out_state_o;
  logic       top_o, bottom_o, timer_tick_o, wave_out_a_o, wave_oe_a_o, wave_out_b_o, wave_oe_b_o;
  int         n_fail = 0, samples_checked = 0, cycles = 0;

  tmr8_timer dut (.*);
  tmr8_pin_model pin (.clk_i(clk_i), .edge_req_i(edge_req), .ext_count_pin_o(ext_count_pin_i));

  always #4 clk_i = ~clk_i;

  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  task chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc

  task wcnt(input logic [7:0] d);
    @(posedge clk_i);
    count_wr_i    <= 1'h1;
    count_wdata_i <= d;
    @(posedge clk_i);
    count_wr_i <= 1'h0;
    #1;
  endtask : wcnt

  task wcmp(input logic b, input logic [7:0] d);
    @(posedge clk_i);
    compare_a_wr_i  <= !b;
    compare_b_wr_i  <= b;
    compare_wdata_i <= d;
    @(posedge clk_i);
    compare_a_wr_i <= 1'h0;
    compare_b_wr_i <= 1'h0;
    #1;
  endtask : wcmp

  task wait_flag(input int b);
    for (int k = 0; k < 100 && timer_flag_register_o[b] !== 1'h1; k++)
    begin
      @(posedge clk_i);
      #1;
    end
  endtask : wait_flag

  task force_a;
    @(posedge clk_i) force_match_strobe_a_i <= 1'h1;
    @(posedge clk_i) force_match_strobe_a_i <= 1'h0;
    cyc(2);
  endtask : force_a

  task pin_edge(input logic [7:0] e);
    @(posedge clk_i) edge_req <= 1'h1;
    @(posedge clk_i) edge_req <= 1'h0;
    cyc(12);
    chk(count_value_o, e);
  endtask : pin_edge

  initial
  begin
    cyc(10);
    rst_b_i <= 1'h1;
    cyc(3);
    chk(count_value_o, CNT_BOTTOM);
    chk(wave_out_state_o, 8'h00);
    wcnt(8'h00);
    chk(bottom_o, 8'h01);
    wcnt(8'hFF);
    chk(top_o, 8'h01);
    wcnt(8'h10);
    cyc(5);
    chk(count_value_o, 8'h10);
    wcmp(1'h0, 8'h20);
    chk(compare_value_a_o, 8'h20);
    timer_mask_register_i <= 3'h2;
    output_action_bits_a_i <= COM_TOGGLE;
    clock_select_field_i <= CS_DIV1;
    wcnt(8'h18);
    chk(count_value_o, 8'h18);
    chk(timer_tick_o, 8'h01);
    wait_flag(FLAG_MATCH_A);
    clock_select_field_i <= CS_STOP;
    chk(irq_o, 8'h02);
    chk(wave_out_state_o, 8'h01);
    timer_mask_register_i <= 3'h0;
    cyc(1);
    chk(irq_o, 8'h00);
    @(posedge clk_i) flag_clear_i <= 3'h2;
    @(posedge clk_i) flag_clear_i <= 3'h0;
    cyc(1);
    chk(timer_flag_register_o, 8'h00);
    wcmp(1'h1, 8'h30);
    chk(compare_value_b_o, 8'h30);
    wcnt(8'h30);
    clock_select_field_i <= CS_DIV1;
    cyc(20);
    chk(timer_flag_register_o[FLAG_MATCH_B], 8'h00);
    wcnt(8'hFE);
    wait_flag(FLAG_OVF);
    clock_select_field_i <= CS_STOP;
    chk(timer_flag_register_o[FLAG_OVF], 8'h01);
    @(posedge clk_i) int_ack_i <= 3'h1;
    @(posedge clk_i) int_ack_i <= 3'h0;
    cyc(1);
    chk(timer_flag_register_o, 8'h00);
    wcnt(8'h40);
    force_a();
    chk(wave_out_state_o[0], 8'h00);
    chk(timer_flag_register_o, 8'h00);
    chk(count_value_o, 8'h40);
    waveform_mode_field_i <= WGM_FAST_MAX;
    force_a();
    waveform_mode_field_i <= WGM_NORMAL;
    cyc(1);
    chk(wave_out_state_o[0], 8'h00);
    output_action_bits_a_i <= COM_SET;
    force_a();
    port_dir_i <= 2'h3;
    cyc(1);
    chk(wave_out_a_o, 8'h01);
    chk(wave_oe_a_o, 8'h01);
    output_action_bits_a_i <= COM_OFF;
    output_action_bits_b_i <= COM_CLEAR;
    port_out_i <= 2'h2;
    force_a();
    chk(wave_out_state_o[0], 8'h01);
    chk(wave_out_a_o, 8'h00);
    chk(wave_out_b_o, 8'h00);
    chk(wave_oe_b_o, 8'h01);
    // Fast PWM: a compare write waits in the buffer until the counter passes top
    waveform_mode_field_i <= WGM_FAST_MAX;
    wcnt(8'hF0);
    wcmp(1'h0, 8'hF8);
    chk(compare_value_a_o, 8'hF8);
    clock_select_field_i <= CS_DIV1;
    cyc(20);
    clock_select_field_i <= CS_STOP;
    chk(timer_flag_register_o[FLAG_MATCH_A], 8'h00);
    wcnt(8'hF6);
    clock_select_field_i <= CS_DIV1;
    wait_flag(FLAG_MATCH_A);
    clock_select_field_i <= CS_STOP;
    chk(count_value_o, 8'hF9);
    waveform_mode_field_i <= WGM_NORMAL;
    wcnt(8'h50);
    clock_select_field_i <= CS_EXT_RISE;
    pin_edge(8'h51);
    pin_edge(8'h51);
    clock_select_field_i <= CS_EXT_FALL;
    pin_edge(8'h51);
    pin_edge(8'h52);
    report_and_stop();
  end
endmodule : tb_top

`default_nettype wire

// file: sim/tmr8_pin_model.sv
// Far-side model: toggles the external count pin on request.
// Assumes requests are spaced wider than the hold time.
`timescale 1ns/100ps
`default_nettype none

module tmr8_pin_model
(
  input  wire logic clk_i,
  input  wire logic edge_req_i,
  output logic      ext_count_pin_o
);
  logic [2:0] hold_reg;
  initial ext_count_pin_o = 1'h0;
  initial hold_reg = 3'h0;
  // Half periods of at least five cycles keep the pin under half the sampling rate
  always @(posedge clk_i)
    if (hold_reg != 3'h0)
      hold_reg <= hold_reg - 3'h1;
    else if (edge_req_i)
    begin
      ext_count_pin_o <= ~ext_count_pin_o;
      hold_reg        <= 3'h4;
    end
endmodule : tmr8_pin_model

`default_nettype wire
